// [verilog/afe_cfg_pkg.sv]
// constants for the sensor front-end configuration and stimulus logic
`default_nettype none
package afe_cfg_pkg;
	localparam int CFG_W          = 16;
	localparam int MODE_BIT       = 15;
	localparam int ROUTE_BIT      = 14;
	localparam int LEVEL_HI       = 13;
	localparam int LEVEL_LO       = 12;
	localparam int GAIN_BIT       = 11;
	localparam int CM_HI          = 10;
	localparam int CM_LO          = 8;
	localparam int OCM_BIT        = 7;
	localparam int STIM_BIT       = 6;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [2:0] EDGE_ZERO  = 3'h0;
	localparam logic [2:0] EDGE_LAST  = 3'h4;
	localparam logic [2:0] EDGE_POS   = 3'h1;
	localparam logic [2:0] EDGE_MID   = 3'h2;
	localparam logic [2:0] EDGE_NEG   = 3'h3;
	localparam logic [2:0] EDGE_STEP  = 3'h1;
	localparam logic [4:0] BIT_ZERO   = 5'h00;
	localparam logic [4:0] BIT_ONE    = 5'h01;
	localparam logic [4:0] BIT_LAST   = 5'h0f;
	localparam int STIM_SHIFT_PCT     = 5;

	typedef enum logic [1:0] {EXC_BASE_HIGHVAL, EXC_BASE_LOWVAL,
		EXC_DBL_HIGHVAL, EXC_DBL_LOWVAL} exc_level_t;
	typedef enum logic [1:0] {CM_HOLD, CM_UP, CM_DOWN} cm_shift_t;
endpackage : afe_cfg_pkg
`default_nettype wire

// [verilog/edge_sync.sv]
// two-flop synchroniser for a single level
`timescale 1ns/100ps
`default_nettype none
module edge_sync
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// level
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end
		else
		begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule : edge_sync
`default_nettype wire

// [verilog/afe_config_diag.sv]
// configuration word shifter, field decode and diagnostic stimulus sequencer
//
// Contract
// RQ1: level code 00/10 base current, 01/11 doubled, per sensor value.
// RQ2: host sets first acquisition: reference path, doubled current, gain five.
// RQ3: host runs three temperature acquisitions in the stated order.
// RQ4: host keeps the common-mode field unchanged in temperature words.
// RQ5: host should use a converter of at least 16 bits.
// RQ6: stimulus enabled and disabled only by the configuration word bit.
// RQ7: stimulus bit low: hold common mode, ignore stimulus pin.
// RQ8: first rising edge starts positive pulse, second ends it.
// RQ9: third rising edge starts negative pulse, fourth ends it.
// RQ10: after fourth edge stop until stimulus bit written to one again.
// RQ11: each pulse shifts common mode five percent of reference.
// RQ12: enable rising clears edge counter; edges while disabled not counted.
`timescale 1ns/100ps
`default_nettype none
module afe_config_diag
	import afe_cfg_pkg::*;
(
	// system clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// serial configuration link
	input  wire logic        spi_clk,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_mosi,
	// shared serial out / stimulus pin, sampled as input here
	input  wire logic        serial_out_stim_pin,
	// decoded configuration
	output logic [15:0]      afe_config_word,
	output logic             measure_select,
	output logic             current_route_sel,
	output exc_level_t       exc_level,
	output logic             gain_high,
	output logic [2:0]       common_mode_level,
	output logic             output_cm_select,
	output logic             stimulus_enable,
	// stimulus state
	output cm_shift_t        cm_shift,
	output logic [2:0]       edge_count,
	output logic             stim_done
);
	// ------------------------------------------------------------
	// link domain: shift in the word on spi_clk
	// ------------------------------------------------------------
	logic [15:0] shift_r;
	logic [15:0] hold_r;
	logic [4:0]  bits_r;
	logic        load_tgl_r;
	logic        frame_clr_n;

	// the link clock stops between frames, so a cut frame is thrown away by
	// the select line itself: it clears the bit counter without a clock edge
	assign frame_clr_n = rst_n & ~spi_cs_n;

	always_ff @(posedge spi_clk or negedge frame_clr_n)
	begin
		if (!frame_clr_n)
			bits_r <= BIT_ZERO;
		else if (bits_r == BIT_LAST)
			bits_r <= BIT_ZERO;
		else
			bits_r <= bits_r + BIT_ONE;
	end

	// link clock may stop after the frame, so the word is latched on the
	// sixteenth edge and a toggle announces it to the system domain
	always_ff @(posedge spi_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shift_r    <= CFG_RESET;
			hold_r     <= CFG_RESET;
			load_tgl_r <= 1'b0;
		end
		else if (!spi_cs_n)
		begin
			shift_r <= {shift_r[14:0], spi_mosi};
			if (bits_r == BIT_LAST)
			begin
				hold_r     <= {shift_r[14:0], spi_mosi};
				load_tgl_r <= ~load_tgl_r;
			end
		end
	end

	// ------------------------------------------------------------
	// crossings into sys_clk
	// ------------------------------------------------------------
	logic tgl_s;
	logic tgl_d_r;
	logic pin_s;
	logic pin_d_r;

	edge_sync u_tgl_sync
	(
		.clk   (sys_clk),
		.rst_n (rst_n),
		.d     (load_tgl_r),
		.q     (tgl_s)
	);

	// the pin idles low, so zero after reset gives no false first edge
	edge_sync u_pin_sync
	(
		.clk   (sys_clk),
		.rst_n (rst_n),
		.d     (serial_out_stim_pin),
		.q     (pin_s)
	);

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tgl_d_r <= 1'b0;
			pin_d_r <= 1'b0;
		end
		else
		begin
			tgl_d_r <= tgl_s;
			pin_d_r <= pin_s;
		end
	end

	logic load_p;
	logic pin_rise;
	assign load_p   = tgl_s ^ tgl_d_r;
	assign pin_rise = pin_s & ~pin_d_r;

	// ------------------------------------------------------------
	// configuration register
	// ------------------------------------------------------------
	// hold_r is stable for many cycles after the toggle, so it is safe here
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			afe_config_word <= CFG_RESET;
		else if (load_p)
			afe_config_word <= hold_r;
	end

	assign measure_select    = afe_config_word[MODE_BIT];
	assign current_route_sel = afe_config_word[ROUTE_BIT];
	assign gain_high         = afe_config_word[GAIN_BIT];
	assign common_mode_level = afe_config_word[CM_HI:CM_LO];
	assign output_cm_select  = afe_config_word[OCM_BIT];
	// RQ6 stimulus enable source
	assign stimulus_enable   = afe_config_word[STIM_BIT];

	// RQ1 level code decode
	always_comb
	begin
		case (afe_config_word[LEVEL_HI:LEVEL_LO])
			2'b00:   exc_level = EXC_BASE_HIGHVAL;
			2'b10:   exc_level = EXC_BASE_LOWVAL;
			2'b01:   exc_level = EXC_DBL_HIGHVAL;
			2'b11:   exc_level = EXC_DBL_LOWVAL;
			default: exc_level = EXC_BASE_HIGHVAL;
		endcase
	end

	// ------------------------------------------------------------
	// stimulus sequencer
	// ------------------------------------------------------------
	// a write of the bit to one (even 1 over 1) rearms the sequence
	logic arm_p;
	assign arm_p = load_p & hold_r[STIM_BIT];

	// a write with the enable bit wins over a pin edge in the same cycle
	logic [2:0] edge_nxt;
	always_comb
	begin
		edge_nxt = edge_count;
		// RQ12 clear on arm
		if (arm_p)
			edge_nxt = EDGE_ZERO;
		// RQ7 ignore pin when disabled
		else if (stimulus_enable && pin_rise && edge_count != EDGE_LAST)
			edge_nxt = edge_count + EDGE_STEP;
	end

	// RQ10 count stops at four
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			edge_count <= EDGE_ZERO;
		else
			edge_count <= edge_nxt;
	end

	assign stim_done = (edge_count == EDGE_LAST);

	// RQ8 RQ9 RQ11 pulse polarity from count
	always_comb
	begin
		cm_shift = CM_HOLD;
		if (stimulus_enable)
		begin
			case (edge_count)
				EDGE_POS: cm_shift = CM_UP;
				EDGE_NEG: cm_shift = CM_DOWN;
				default: cm_shift = CM_HOLD;
			endcase
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// one named step per counted edge; a write with the enable bit wins
	sequence first_rise_s;
		stimulus_enable && !arm_p && pin_rise && edge_count == EDGE_ZERO;
	endsequence

	sequence second_rise_s;
		stimulus_enable && !arm_p && pin_rise && edge_count == EDGE_POS;
	endsequence

	sequence third_rise_s;
		stimulus_enable && !arm_p && pin_rise && edge_count == EDGE_MID;
	endsequence

	sequence fourth_rise_s;
		stimulus_enable && !arm_p && pin_rise && edge_count == EDGE_NEG;
	endsequence

	hold_when_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
		!stimulus_enable |-> cm_shift == CM_HOLD)
		else $error("common mode moved while stimulus off");

	no_count_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
		!stimulus_enable && !arm_p |=> $stable(edge_count))
		else $error("edge counter moved while stimulus off");

	ignore_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ7
		!stimulus_enable && !arm_p && pin_rise |=> edge_count == $past(edge_count))
		else $error("pin edge counted while stimulus off");

	pos_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
		first_rise_s ##1 stimulus_enable |-> cm_shift == CM_UP)
		else $error("positive pulse did not start");

	pos_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
		second_rise_s |=> cm_shift == CM_HOLD)
		else $error("positive pulse did not end");

	neg_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ9
		third_rise_s ##1 stimulus_enable |-> cm_shift == CM_DOWN)
		else $error("negative pulse did not start");

	neg_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ9
		fourth_rise_s |=> stim_done && cm_shift == CM_HOLD)
		else $error("negative pulse did not end");

	edge_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ8
		stimulus_enable && !arm_p && pin_rise && !stim_done
		|=> edge_count == $past(edge_count) + EDGE_STEP)
		else $error("counted edge did not advance the counter by one");

	count_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		edge_count <= EDGE_LAST)
		else $error("edge counter beyond fourth edge");

	stop_after_four_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ10
		stim_done && !arm_p |=> stim_done && cm_shift == CM_HOLD)
		else $error("sequence ran past fourth edge");

	arm_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ12
		arm_p |=> edge_count == EDGE_ZERO)
		else $error("edge counter not cleared on enable write");

	pulse_up_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11
		cm_shift == CM_UP |-> stimulus_enable && edge_count == EDGE_POS)
		else $error("upward shift outside the positive pulse");

	pulse_down_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ11
		cm_shift == CM_DOWN |-> stimulus_enable && edge_count == EDGE_NEG)
		else $error("downward shift outside the negative pulse");

	level_dbl_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
		afe_config_word[LEVEL_LO] |-> exc_level inside {EXC_DBL_HIGHVAL, EXC_DBL_LOWVAL})
		else $error("doubled current code decoded wrong");

	level_base_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
		!afe_config_word[LEVEL_LO] |-> exc_level inside {EXC_BASE_HIGHVAL, EXC_BASE_LOWVAL})
		else $error("base current code decoded wrong");

	sensor_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ1
		afe_config_word[LEVEL_HI] |-> exc_level inside {EXC_BASE_LOWVAL, EXC_DBL_LOWVAL})
		else $error("sensor value of the level code decoded wrong");

	word_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RQ6
		load_p |=> afe_config_word == $past(hold_r))
		else $error("configuration word not loaded");

	// link side checks run on the link clock itself
	frame_tgl_a: assert property (@(posedge spi_clk) disable iff (!rst_n) // RQ6
		!spi_cs_n && bits_r != BIT_LAST |=> $stable(load_tgl_r))
		else $error("word announced before sixteenth bit");

	frame_done_a: assert property (@(posedge spi_clk) disable iff (!rst_n) // RQ6
		!spi_cs_n && bits_r == BIT_LAST |=> load_tgl_r != $past(load_tgl_r))
		else $error("complete word not announced");
endmodule : afe_config_diag
`default_nettype wire

// [tb/afe_host_model.sv]
// behavioural host: serial word writer and stimulus pin driver
`timescale 1ns/100ps
`default_nettype none
module afe_host_model
(
	// system clock
	input  wire logic sys_clk,
	// serial link and stimulus pin
	output logic      spi_clk,
	output logic      spi_cs_n,
	output logic      spi_mosi,
	output logic      serial_out_stim_pin
);
	initial
	begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
		serial_out_stim_pin = 1'b0;
	end
	task automatic send_word(input logic [15:0] w);
		send_bits(w, 16);
	endtask : send_word
	// a cut frame sends only the first nbits, msb first
	task automatic send_bits(input logic [15:0] w, input int nbits);
		#13;
		spi_cs_n = 1'b0;
		for (int i = 15; i > 15 - nbits; i--)
		begin
			spi_mosi = w[i];
			#32 spi_clk = 1'b1;
			#32 spi_clk = 1'b0;
		end
		spi_cs_n = 1'b1;
		// released line must not keep the last bit
		spi_mosi = ~spi_mosi;
	endtask : send_bits
	// high and low well above the three-cycle minimum
	task automatic pulse_pin();
		@(posedge sys_clk) serial_out_stim_pin <= 1'b1;
		repeat (6) @(posedge sys_clk);
		serial_out_stim_pin <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask : pulse_pin
endmodule : afe_host_model
`default_nettype wire

// [tb/afe_config_diag_test.sv]
// self-checking bench for configuration decode and stimulus sequencer
`timescale 1ns/100ps
`default_nettype none
module afe_config_diag_test
	import afe_cfg_pkg::*;
;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        spi_clk, spi_cs_n, spi_mosi, serial_out_stim_pin;
	logic [15:0] afe_config_word, w;
	logic        measure_select, current_route_sel, gain_high;
	logic        output_cm_select, stimulus_enable, stim_done;
	logic [2:0]  common_mode_level, edge_count, c;
	exc_level_t  exc_level;
	cm_shift_t   cm_shift;
	int          errors = 0;
	int          checked = 0;
	int          k;
	always #4 sys_clk = ~sys_clk;
	afe_host_model afe_host_model_i (.sys_clk(sys_clk), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .serial_out_stim_pin(serial_out_stim_pin));
	afe_config_diag afe_config_diag_i (.sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .serial_out_stim_pin(serial_out_stim_pin),
		.afe_config_word(afe_config_word), .measure_select(measure_select),
		.current_route_sel(current_route_sel), .exc_level(exc_level), .gain_high(gain_high),
		.common_mode_level(common_mode_level), .output_cm_select(output_cm_select),
		.stimulus_enable(stimulus_enable), .cm_shift(cm_shift), .edge_count(edge_count),
		.stim_done(stim_done));
	// ----
	// checks
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// expected level decode: low bit doubles, high bit picks the low-value sensor
	function automatic exc_level_t exp_level(input logic [15:0] v);
		case ({v[LEVEL_HI], v[LEVEL_LO]})
			2'b00:   return EXC_BASE_HIGHVAL;
			2'b10:   return EXC_BASE_LOWVAL;
			2'b01:   return EXC_DBL_HIGHVAL;
			default: return EXC_DBL_LOWVAL;
		endcase
	endfunction : exp_level
	// expected common-mode shift after n counted edges
	function automatic cm_shift_t exp_shift(input logic [2:0] n, input logic en);
		if (en && n == EDGE_POS)
			return CM_UP;
		if (en && n == EDGE_NEG)
			return CM_DOWN;
		return CM_HOLD;
	endfunction : exp_shift
	task automatic write_chk(input logic [15:0] v);
		afe_host_model_i.send_word(v);
		repeat (10) @(posedge sys_clk);
		#1;
		chk(afe_config_word, v);
		chk({measure_select, current_route_sel, gain_high},
			{v[MODE_BIT], v[ROUTE_BIT], v[GAIN_BIT]});
		chk({output_cm_select, stimulus_enable}, {v[OCM_BIT], v[STIM_BIT]});
		chk(common_mode_level, v[CM_HI:CM_LO]);
		chk(exc_level, exp_level(v));
	endtask : write_chk
	task automatic stim_chk(input logic [2:0] n, input logic en);
		afe_host_model_i.pulse_pin();
		#1;
		chk(edge_count, n);
		chk(cm_shift, exp_shift(n, en));
		chk(stim_done, n == EDGE_LAST);
	endtask : stim_chk
	task automatic give_verdict();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	// ----
	// sequence
	// ----
	initial
	begin
		void'($urandom(51035));
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk(afe_config_word, CFG_RESET);
		repeat (12)
		begin
			w = 16'($urandom) & 16'hffbf;
			write_chk(w);
			stim_chk(3'h0, 1'b0);
		end
		// cut frames are thrown away and leave the word as it was
		repeat (3)
		begin
			k = 1 + int'($urandom % 15);
			afe_host_model_i.send_bits(16'($urandom), k);
			repeat (10) @(posedge sys_clk);
			#1;
			chk(afe_config_word, w);
			w = 16'($urandom) & 16'hffbf;
			write_chk(w);
		end
		c = 3'($urandom);
		// the host writes the three acquisition words with the same common-mode field c
		write_chk({4'hd, 1'b0, c, 8'h80});
		write_chk({4'hc, 1'b1, c, 8'h80});
		write_chk({4'h8, 1'b1, c, 8'h80});
		// second pass proves rearm after a finished run
		repeat (2)
		begin
			write_chk(16'($urandom) | 16'h0040);
			for (int n = 1; n <= 5; n++)
				stim_chk((n > 4) ? EDGE_LAST : 3'(n), 1'b1);
		end
		write_chk(16'h0040);
		stim_chk(3'h1, 1'b1);
		write_chk(16'h0000);
		stim_chk(3'h1, 1'b0);
		give_verdict();
	end
	// about 30 us expected, ample margin
	initial
	begin
		#150us;
		errors++;
		give_verdict();
	end
endmodule : afe_config_diag_test
`default_nettype wire
